// >>> gbdac_consts.vh
// gbdac_consts.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the gate-bias dac control modules; definitions only
`ifndef GBDAC_CONSTS_VH
`define GBDAC_CONSTS_VH

// word byte addresses on the wishbone slave
`define GBDAC_ADR_CH0_LOW       8'h00
`define GBDAC_ADR_CH0_HIGH      8'h04
`define GBDAC_ADR_CH0_FINE_IMM  8'h08
`define GBDAC_ADR_CH0_FINE_DLY  8'h0C
`define GBDAC_ADR_CH0_FINE_CAL  8'h10
`define GBDAC_ADR_CH0_FINE_CALD 8'h14
`define GBDAC_ADR_CH0_COARSE    8'h18
`define GBDAC_ADR_CH1_BASE      8'h20
`define GBDAC_ADR_LOAD          8'h40
`define GBDAC_ADR_REFCTL        8'h44
`define GBDAC_ADR_STATUS        8'h48
`define GBDAC_ADR_CORR0         8'h4C
`define GBDAC_ADR_CORR1         8'h50
`define GBDAC_ADR_OUT0          8'h54
`define GBDAC_ADR_OUT1          8'h58

// coarse control word: bit 0 immediate, bits 2:1 calibration select
`define GBDAC_CC_IMM_BIT        0
`define GBDAC_CC_CAL_LO         1
`define GBDAC_CC_CAL_HI         2
// reference control fields
`define GBDAC_REF_MODE_LSB      0
`define GBDAC_REF_CH0_PWR_BIT   2
`define GBDAC_REF_CH1_PWR_BIT   3
`define GBDAC_REF_BG_FORCE_BIT  4
`define GBDAC_REF_CONV_REQ_BIT  5
`define GBDAC_REF_MODE_PERM     2'b11

`define GBDAC_RST_CODE8         8'h00
`define GBDAC_RST_CODE10        10'h000

// reference settling: worst case time and clock
`define GBDAC_REF_SETTLE_NS     81000
`define GBDAC_CLK_PERIOD_NS     100
`define GBDAC_REF_SETTLE_CYC    ((`GBDAC_REF_SETTLE_NS + `GBDAC_CLK_PERIOD_NS - 1) / `GBDAC_CLK_PERIOD_NS)

`endif

// >>> gbdac_channel.v
// gbdac_channel.v: one channel of input and hidden output code registers
// assumes: write strobes come from the bus slave on the same clock
`timescale 1ns/1ps
`include "gbdac_consts.vh"

module gbdac_channel #(
  parameter CW = 8,
  parameter FW = 10
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire [CW-1:0] wr_data_c,
  input  wire [FW-1:0] wr_data_f,
  input  wire          wr_low,
  input  wire          wr_high,
  input  wire          wr_fine,
  input  wire          fine_imm,
  input  wire          fine_cal,
  input  wire          coarse_imm,
  input  wire [1:0]    coarse_cal,
  input  wire [FW-1:0] corr,
  input  wire          load,
  output reg  [CW-1:0] low_in_ff,
  output reg  [CW-1:0] high_in_ff,
  output reg  [FW-1:0] fine_in_ff,
  output reg  [CW-1:0] low_out_ff,
  output reg  [CW-1:0] high_out_ff,
  output reg  [FW-1:0] fine_out_ff
);

  reg          cal_pend_ff;
  reg          fine_pend_ff;
  reg [FW-1:0] nxt_fine_out;
  wire [FW-1:0] fine_cal_val;
  wire          any_cal;

  // correction is two's complement, so one adder does add and subtract
  assign fine_cal_val = fine_in_ff + corr;
  assign any_cal      = fine_cal | (|coarse_cal);

  always @* begin
    nxt_fine_out = fine_out_ff;
    if (wr_fine && fine_imm) begin
      nxt_fine_out = fine_cal ? (wr_data_f + corr) : wr_data_f;
    end else if (load && fine_pend_ff) begin
      // a fine code already moved is not moved again, so its correction survives
      nxt_fine_out = cal_pend_ff ? fine_cal_val : fine_in_ff;
    end else if ((wr_low || wr_high) && coarse_imm && (|coarse_cal)) begin
      nxt_fine_out = fine_cal_val;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_in_ff   <= `GBDAC_RST_CODE8;
      high_in_ff  <= `GBDAC_RST_CODE8;
      fine_in_ff  <= `GBDAC_RST_CODE10;
      low_out_ff  <= `GBDAC_RST_CODE8;
      high_out_ff <= `GBDAC_RST_CODE8;
      fine_out_ff <= `GBDAC_RST_CODE10;
      cal_pend_ff <= 1'b0;
      fine_pend_ff <= 1'b0;
    end else begin
      if (wr_low) begin
        low_in_ff <= wr_data_c;
      end
      if (wr_high) begin
        high_in_ff <= wr_data_c;
      end
      if (wr_fine) begin
        fine_in_ff  <= wr_data_f;
        cal_pend_ff <= fine_cal;
      end else if ((wr_low || wr_high) && (|coarse_cal)) begin
        cal_pend_ff <= 1'b1;
      end else if (load) begin
        cal_pend_ff <= 1'b0;
      end
      // only a deferred write leaves the fine output waiting for a load
      if (wr_fine) begin
        fine_pend_ff <= ~fine_imm;
      end else if ((wr_low || wr_high) && !coarse_imm && (|coarse_cal)) begin
        fine_pend_ff <= 1'b1;
      end else if (load) begin
        fine_pend_ff <= 1'b0;
      end
      // wipers move only on a transfer, never on an input write alone
      if ((wr_low && coarse_imm) || load) begin
        low_out_ff <= wr_low ? wr_data_c : low_in_ff;
      end
      if ((wr_high && coarse_imm) || load) begin
        high_out_ff <= wr_high ? wr_data_c : high_in_ff;
      end
      fine_out_ff <= nxt_fine_out;
    end
  end

endmodule // gbdac_channel

// >>> gbdac_ctrl.v
// gbdac_ctrl.v: gate-bias dac update control, two channels, wishbone slave
// assumes: classic wishbone master on clk; one-cycle registered ack
// Operation
// - each channel keeps user-written 8-bit low and high wiper codes and a 10-bit fine code.
// - the analog level is ref/256*low plus ref/256*(high-low)*fine/1024, unipolar.
// - a wiper moves only when its hidden output register loads, not on an input write.
// - hidden output registers are not writable by software, only via transfers.
// - selecting low or high calibration adds or subtracts a correction to the fine code.
// - selecting fine calibration loads the signed-corrected fine code into the output.
// - transfers happen right after an immediate-mode write or on the load command.
// - the fine register address chosen sets calibration on/off and immediate/deferred.
// - an unpowered reference is powered and settled before a conversion may start.
//
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "gbdac_consts.vh"

module gbdac_ctrl #(
  parameter CW         = 8,
  parameter FW         = 10,
  parameter SETTLE_CYC = `GBDAC_REF_SETTLE_CYC
) (
  input  wire          clk,
  input  wire          rst_b,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  output reg  [CW-1:0] ch0_low_wiper_ff,
  output reg  [CW-1:0] ch0_high_wiper_ff,
  output reg  [FW-1:0] ch0_fine_interp_ff,
  output reg  [CW-1:0] ch1_low_wiper_ff,
  output reg  [CW-1:0] ch1_high_wiper_ff,
  output reg  [FW-1:0] ch1_fine_interp_ff,
  output reg           ref_power_ff,
  output reg           ref_ready_ff,
  output reg           conv_start_ff
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  // ack low gates the request, so one held over the ack edge is taken only once
  wire       req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr   = req & wb_we_i & wb_sel_i[0];
  wire       wr_h = req & wb_we_i & wb_sel_i[1];
  // channel 1 mirrors channel 0 at a fixed offset
  wire       ch1  = wb_adr_i[5];
  wire [7:0] loc  = ch1 ? (wb_adr_i - `GBDAC_ADR_CH1_BASE) : wb_adr_i;
  wire       in_ch = (wb_adr_i < 8'h40);

  reg  [2:0]    coarse_ctl_ff [0:1];
  reg  [FW-1:0] corr_ff       [0:1];
  reg  [5:0]    refctl_ff;
  reg  [15:0]   settle_cnt_ff;
  reg           conv_pend_ff;

  wire [CW-1:0] li0, hi0, li1, hi1, lo0, ho0, lo1, ho1;
  wire [FW-1:0] fi0, fi1, fo0, fo1;

  wire w_low  = wr & in_ch & (loc == `GBDAC_ADR_CH0_LOW);
  wire w_high = wr & in_ch & (loc == `GBDAC_ADR_CH0_HIGH);
  // four fine addresses: immediate/deferred times plain/calibrated
  wire w_fine = wr & in_ch & ((loc == `GBDAC_ADR_CH0_FINE_IMM) | (loc == `GBDAC_ADR_CH0_FINE_DLY)
              | (loc == `GBDAC_ADR_CH0_FINE_CAL) | (loc == `GBDAC_ADR_CH0_FINE_CALD));
  wire f_imm  = (loc == `GBDAC_ADR_CH0_FINE_IMM) | (loc == `GBDAC_ADR_CH0_FINE_CAL);
  wire f_cal  = (loc == `GBDAC_ADR_CH0_FINE_CAL) | (loc == `GBDAC_ADR_CH0_FINE_CALD);
  wire w_load = wr & (wb_adr_i == `GBDAC_ADR_LOAD);
  wire [1:0] load_ch = w_load ? wb_dat_i[1:0] : 2'b00;

  ////////////////////////////////////////////////////////////////////////////////
  // channels
  gbdac_channel #(.CW(CW), .FW(FW)) u_ch0 (
    .clk        (clk),
    .rst_b      (rst_b),
    .wr_data_c  (wb_dat_i[CW-1:0]),
    .wr_data_f  (wb_dat_i[FW-1:0]),
    .wr_low     (w_low & ~ch1),
    .wr_high    (w_high & ~ch1),
    .wr_fine    (w_fine & wr_h & ~ch1),
    .fine_imm   (f_imm),
    .fine_cal   (f_cal),
    .coarse_imm (coarse_ctl_ff[0][`GBDAC_CC_IMM_BIT]),
    .coarse_cal (coarse_ctl_ff[0][`GBDAC_CC_CAL_HI:`GBDAC_CC_CAL_LO]),
    .corr       (corr_ff[0]),
    .load       (load_ch[0]),
    .low_in_ff  (li0),
    .high_in_ff (hi0),
    .fine_in_ff (fi0),
    .low_out_ff (lo0),
    .high_out_ff(ho0),
    .fine_out_ff(fo0)
  );

  gbdac_channel #(.CW(CW), .FW(FW)) u_ch1 (
    .clk        (clk),
    .rst_b      (rst_b),
    .wr_data_c  (wb_dat_i[CW-1:0]),
    .wr_data_f  (wb_dat_i[FW-1:0]),
    .wr_low     (w_low & ch1),
    .wr_high    (w_high & ch1),
    .wr_fine    (w_fine & wr_h & ch1),
    .fine_imm   (f_imm),
    .fine_cal   (f_cal),
    .coarse_imm (coarse_ctl_ff[1][`GBDAC_CC_IMM_BIT]),
    .coarse_cal (coarse_ctl_ff[1][`GBDAC_CC_CAL_HI:`GBDAC_CC_CAL_LO]),
    .corr       (corr_ff[1]),
    .load       (load_ch[1]),
    .low_in_ff  (li1),
    .high_in_ff (hi1),
    .fine_in_ff (fi1),
    .low_out_ff (lo1),
    .high_out_ff(ho1),
    .fine_out_ff(fo1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registers, reference sequencing and outputs
  wire ref_forced = (refctl_ff[1:0] == `GBDAC_REF_MODE_PERM) & (refctl_ff[`GBDAC_REF_CH0_PWR_BIT]
                  | refctl_ff[`GBDAC_REF_CH1_PWR_BIT] | refctl_ff[`GBDAC_REF_BG_FORCE_BIT]);
  wire conv_req   = wr & (wb_adr_i == `GBDAC_ADR_REFCTL) & wb_dat_i[`GBDAC_REF_CONV_REQ_BIT];
  wire settled    = (settle_cnt_ff == SETTLE_CYC[15:0]);

  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h0000_0000;
    if (in_ch) begin
      case (loc)
        `GBDAC_ADR_CH0_LOW:      nxt_rdata = {24'h00_0000, ch1 ? li1 : li0};
        `GBDAC_ADR_CH0_HIGH:     nxt_rdata = {24'h00_0000, ch1 ? hi1 : hi0};
        `GBDAC_ADR_CH0_FINE_IMM,
        `GBDAC_ADR_CH0_FINE_DLY,
        `GBDAC_ADR_CH0_FINE_CAL,
        `GBDAC_ADR_CH0_FINE_CALD: nxt_rdata = {22'h00_0000, ch1 ? fi1 : fi0};
        `GBDAC_ADR_CH0_COARSE:   nxt_rdata = {29'h0000_0000, coarse_ctl_ff[ch1]};
        default:                 nxt_rdata = 32'h0000_0000;
      endcase
    end else begin
      case (wb_adr_i)
        `GBDAC_ADR_REFCTL: nxt_rdata = {26'h000_0000, refctl_ff};
        `GBDAC_ADR_STATUS: nxt_rdata = {29'h0000_0000, conv_pend_ff, ref_ready_ff, ref_power_ff};
        `GBDAC_ADR_CORR0:  nxt_rdata = {22'h00_0000, corr_ff[0]};
        `GBDAC_ADR_CORR1:  nxt_rdata = {22'h00_0000, corr_ff[1]};
        // read-only view of hidden outputs; no write path exists
        `GBDAC_ADR_OUT0:   nxt_rdata = {6'h00, fo0, ho0, lo0};
        `GBDAC_ADR_OUT1:   nxt_rdata = {6'h00, fo1, ho1, lo1};
        default:           nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h0000_0000;
      coarse_ctl_ff[0]   <= 3'h0;
      coarse_ctl_ff[1]   <= 3'h0;
      corr_ff[0]         <= `GBDAC_RST_CODE10;
      corr_ff[1]         <= `GBDAC_RST_CODE10;
      refctl_ff          <= 6'h00;
      settle_cnt_ff      <= 16'h0000;
      conv_pend_ff       <= 1'b0;
      ref_power_ff       <= 1'b0;
      ref_ready_ff       <= 1'b0;
      conv_start_ff      <= 1'b0;
      ch0_low_wiper_ff   <= `GBDAC_RST_CODE8;
      ch0_high_wiper_ff  <= `GBDAC_RST_CODE8;
      ch0_fine_interp_ff <= `GBDAC_RST_CODE10;
      ch1_low_wiper_ff   <= `GBDAC_RST_CODE8;
      ch1_high_wiper_ff  <= `GBDAC_RST_CODE8;
      ch1_fine_interp_ff <= `GBDAC_RST_CODE10;
    end else begin
      wb_ack_o <= req;
      // read data is zero outside the ack cycle so a bus or-mux needs no gating
      wb_dat_o <= req ? nxt_rdata : 32'h0000_0000;
      if (wr && in_ch && loc == `GBDAC_ADR_CH0_COARSE) begin
        coarse_ctl_ff[ch1] <= wb_dat_i[2:0];
      end
      if (wr && wr_h && wb_adr_i == `GBDAC_ADR_CORR0) begin
        corr_ff[0] <= wb_dat_i[FW-1:0];
      end
      if (wr && wr_h && wb_adr_i == `GBDAC_ADR_CORR1) begin
        corr_ff[1] <= wb_dat_i[FW-1:0];
      end
      if (wr && wb_adr_i == `GBDAC_ADR_REFCTL) begin
        // the conversion request bit is a pulse and is never stored
        refctl_ff <= {1'b0, wb_dat_i[4:0]};
      end
      // settling count restarts whenever the reference is unpowered
      conv_start_ff <= 1'b0;
      if (conv_req) begin
        conv_pend_ff <= 1'b1;
      end else if (conv_pend_ff && settled) begin
        conv_pend_ff  <= 1'b0;
        conv_start_ff <= 1'b1;
      end
      ref_power_ff <= ref_forced | conv_req | conv_pend_ff;
      if (!ref_power_ff) begin
        settle_cnt_ff <= 16'h0000;
      end else if (!settled) begin
        settle_cnt_ff <= settle_cnt_ff + 16'h0001;
      end
      // ready waits for the worst-case settle count, not the typical one
      ref_ready_ff <= ref_power_ff & settled;
      // outputs feed the analog dac per ref/256 coarse plus fine interpolation
      ch0_low_wiper_ff   <= lo0;
      ch0_high_wiper_ff  <= ho0;
      ch0_fine_interp_ff <= fo0;
      ch1_low_wiper_ff   <= lo1;
      ch1_high_wiper_ff  <= ho1;
      ch1_fine_interp_ff <= fo1;
    end
  end

endmodule // gbdac_ctrl

// >>> gbdac_ctrl_sva.sv
// gbdac_ctrl_sva.sv: port-level assertions for the gate-bias dac control block
// assumes: bound into gbdac_ctrl; one clock domain, asynchronous active-low reset
`timescale 1ns/1ps
module gbdac_ctrl_sva #(
  parameter CW         = 8,
  parameter FW         = 10,
  parameter SETTLE_CYC = 810
) (
  input wire          clk,
  input wire          rst_b,
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire [31:0]   wb_dat_o,
  input wire          wb_ack_o,
  input wire [CW-1:0] ch0_low_wiper_ff,
  input wire [CW-1:0] ch0_high_wiper_ff,
  input wire [FW-1:0] ch0_fine_interp_ff,
  input wire [CW-1:0] ch1_low_wiper_ff,
  input wire [CW-1:0] ch1_high_wiper_ff,
  input wire [FW-1:0] ch1_fine_interp_ff,
  input wire          ref_power_ff,
  input wire          ref_ready_ff,
  input wire          conv_start_ff
);
  // cycles the reference power has stood; saturates so a long run cannot wrap
  reg  [15:0] pwr_cnt_ff;
  wire [4*CW+2*FW-1:0] wipers = {ch0_low_wiper_ff, ch0_high_wiper_ff, ch0_fine_interp_ff,
                                 ch1_low_wiper_ff, ch1_high_wiper_ff, ch1_fine_interp_ff};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_cnt_ff <= 16'h0000;
    end else if (!ref_power_ff) begin
      pwr_cnt_ff <= 16'h0000;
    end else if (pwr_cnt_ff != 16'hffff) begin
      pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_wiper_after_ack: assert property ($changed(wipers) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("output code moved without a bus transfer");
  a_conv_pulse: assert property (conv_start_ff |=> !conv_start_ff)
    else $error("conversion start longer than one cycle");
  a_conv_when_ready: assert property (conv_start_ff |-> ref_ready_ff || $past(ref_ready_ff))
    else $error("conversion started before reference settled");
  a_ready_settled: assert property ($rose(ref_ready_ff) |-> pwr_cnt_ff >= SETTLE_CYC - 1)
    else $error("reference ready too early");
  a_ready_bound: assert property (pwr_cnt_ff >= SETTLE_CYC + 4 |-> ref_ready_ff)
    else $error("reference ready too late");
  a_ready_powered: assert property ($rose(ref_ready_ff) |-> ref_power_ff)
    else $error("reference ready while unpowered");
endmodule // gbdac_ctrl_sva

bind gbdac_ctrl gbdac_ctrl_sva #(.CW(CW), .FW(FW), .SETTLE_CYC(SETTLE_CYC)) i_gbdac_ctrl_sva (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ch0_low_wiper_ff(ch0_low_wiper_ff), .ch0_high_wiper_ff(ch0_high_wiper_ff),
  .ch0_fine_interp_ff(ch0_fine_interp_ff), .ch1_low_wiper_ff(ch1_low_wiper_ff),
  .ch1_high_wiper_ff(ch1_high_wiper_ff), .ch1_fine_interp_ff(ch1_fine_interp_ff),
  .ref_power_ff(ref_power_ff), .ref_ready_ff(ref_ready_ff), .conv_start_ff(conv_start_ff));

// >>> testbench.sv
// testbench.sv: self-checking bench for the gate-bias dac control block
// assumes: gbdac_ctrl and its bound checker are compiled first
`timescale 1ns/1ps
module testbench;
  localparam SC = 8;
  reg         clk, rst_b, cyc, stb, we;
  reg  [7:0]  adr, base, lo, hi;
  reg  [3:0]  sel;
  reg  [31:0] dat, rd;
  reg  [9:0]  d, corr;
  wire [31:0] dat_o;
  wire        ack, pwr, rdy, cst;
  wire [7:0]  l0, h0, l1, h1;
  wire [9:0]  f0, f1;
  reg  [7:0]  elo [0:1];
  reg  [7:0]  ehi [0:1];
  reg  [9:0]  efi [0:1];
  integer     failures, check_count, n, k, b, r;
  bit         c;
  gbdac_ctrl #(.SETTLE_CYC(SC)) i_gbdac_ctrl (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .ch0_low_wiper_ff(l0), .ch0_high_wiper_ff(h0),
    .ch0_fine_interp_ff(f0), .ch1_low_wiper_ff(l1), .ch1_high_wiper_ff(h1),
    .ch1_fine_interp_ff(f1), .ref_power_ff(pwr), .ref_ready_ff(rdy), .conv_start_ff(cst));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function [9:0] fexp(input [9:0] dv, input [9:0] cv, input bit cal);
    fexp = cal ? dv + cv : dv;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // single classic cycle; request held until ack is sampled, then one idle cycle
  task wb(input bit w, input [7:0] a, input [31:0] dv, input [3:0] s);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= dv;
      sel <= s;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) failures = failures + 1;
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task chk_out(input bit ch);
    begin
      repeat (3) @(posedge clk);
      chk(ch ? {6'h00, f1, h1, l1} : {6'h00, f0, h0, l0}, {6'h00, efi[ch], ehi[ch], elo[ch]});
    end
  endtask
  task wait_sig(input bit which);
    begin
      n = 0;
      while ((which ? cst : rdy) !== 1'b1 && n < 200) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, adr, sel, dat, rst_b, failures, check_count} = 0;
    for (k = 0; k < 2; k = k + 1) {elo[k], ehi[k], efi[k]} = 0;
    r = $urandom(32'h0000_f14f);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chk_out(0);
    chk_out(1);
    for (r = 0; r < 4; r = r + 1) begin
      c = r[0];
      base = c ? 8'h20 : 8'h00;
      lo = $urandom;
      hi = $urandom;
      wb(1, base + 8'h18, 32'h0000_0000, 4'hf);
      wb(1, base, {24'h0, lo}, 4'hf);
      wb(1, base + 8'h04, {24'h0, hi}, 4'hf);
      wb(1, 8'h54 + 4 * c, 32'h03ff_ffff, 4'hf);
      chk_out(c);
      wb(0, 8'h54 + 4 * c, 32'h0000_0000, 4'hf);
      chk(rd, {6'h00, efi[c], ehi[c], elo[c]});
      wb(1, 8'h40, c ? 32'h0000_0002 : 32'h0000_0001, 4'h1);
      elo[c] = lo;
      ehi[c] = hi;
      chk_out(c);
      wb(1, base + 8'h18, 32'h0000_0001, 4'hf);
      lo = ~lo;
      wb(1, base, {24'h0, lo}, 4'hf);
      elo[c] = lo;
      chk_out(c);
      wb(1, base, {24'h0, ~lo}, 4'h0);
      chk_out(c);
      for (k = 0; k < 4; k = k + 1) begin
        corr = (k == 3) ? 10'h3ff : $urandom;
        d = (r == 0) ? 10'h3ff : $urandom;
        wb(1, 8'h4c + 4 * c, {22'h0, corr}, 4'h3);
        wb(1, base + 8'h08 + 4 * k, {22'h0, d}, 4'h3);
        if (k[0] == 1'b0) efi[c] = fexp(d, corr, k >= 2);
        chk_out(c);
        wb(1, 8'h40, c ? 32'h0000_0002 : 32'h0000_0001, 4'h1);
        efi[c] = fexp(d, corr, k >= 2);
        chk_out(c);
      end
      // immediate coarse write with low or high calibration: fine input plus a fresh correction
      corr = ~corr;
      wb(1, 8'h4c + 4 * c, {22'h0, corr}, 4'h3);
      wb(1, base + 8'h18, r[1] ? 32'h0000_0005 : 32'h0000_0003, 4'hf);
      lo = $urandom;
      wb(1, base + 4 * r[1], {24'h0, lo}, 4'hf);
      if (r[1]) ehi[c] = lo;
      if (!r[1]) elo[c] = lo;
      efi[c] = fexp(d, corr, 1);
      chk_out(c);
    end
    // monotonic use: low and high alternate, no calibration, fine inverted while low > high
    wb(1, 8'h18, 32'h0000_0001, 4'hf);
    d = $urandom;
    for (k = 0; k < 4; k = k + 1) begin
      lo = $urandom;
      wb(1, 4 * k[0], {24'h0, lo}, 4'hf);
      if (k[0]) ehi[0] = lo;
      if (!k[0]) elo[0] = lo;
      efi[0] = (elo[0] > ehi[0]) ? ~d : d;
      wb(1, 8'h08, {22'h0, efi[0]}, 4'h3);
      chk_out(0);
    end
    wb(0, 8'h7c, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0000);
    for (b = 2; b < 5; b = b + 1) begin
      wb(1, 8'h44, 32'h0000_0003, 4'h1);
      repeat (4) @(posedge clk);
      chk({31'h0, pwr}, 32'h0000_0000);
      wb(1, 8'h44, 32'h0000_0003 | (32'h0000_0001 << b), 4'h1);
      wait_sig(0);
      chk({31'h0, pwr}, 32'h0000_0001);
      chk({31'h0, rdy}, 32'h0000_0001);
      chk({31'h0, n >= SC}, 32'h0000_0001);
    end
    wb(0, 8'h48, 32'h0000_0000, 4'hf);
    chk(rd & 32'h0000_0003, 32'h0000_0003);
    wb(1, 8'h44, 32'h0000_0033, 4'h1);
    wait_sig(1);
    chk({31'h0, cst}, 32'h0000_0001);
    wb(1, 8'h44, 32'h0000_0000, 4'h1);
    repeat (4) @(posedge clk);
    chk({31'h0, pwr}, 32'h0000_0000);
    wb(1, 8'h44, 32'h0000_0020, 4'h1);
    wait_sig(1);
    chk({31'h0, cst}, 32'h0000_0001);
    chk({31'h0, n >= SC}, 32'h0000_0001);
    summarize;
  end
endmodule // testbench
